// ### rtl/elc_defines.vh
// constants for the exception and low-power controller
`ifndef ELC_DEFINES_VH
`define ELC_DEFINES_VH
`define ELC_NUM_IRQ        8
`define ELC_IRQ_W          3
`define ELC_CNT_W          12
`define ELC_REC_LONG       12'hFFF
`define ELC_REC_SHORT      12'h01F
`define ELC_VEC_NONE       4'h0
`define ELC_VEC_SWI        4'h1
`define ELC_VEC_RESET      4'h2
`define ELC_VEC_IRQ_BASE   4'h8
`endif

// ### rtl/elc_recovery_counter.v
// twelve-bit counter timing stop recovery on the oscillator falling edge
`timescale 1ns/1ps
module elc_recovery_counter (
   // clock and reset
   input  wire        core_clk_i,
   input  wire        reset_i,
   // control
   input  wire        clear_i,
   input  wire        short_i,
   // status
   output reg         done_o
);
`include "elc_defines.vh"
   reg [`ELC_CNT_W-1:0] cnt_q;
   wire [`ELC_CNT_W-1:0] limit;
   assign limit = short_i ? `ELC_REC_SHORT : `ELC_REC_LONG;
   // counts on falling edge; held clear while in stop
   always @(negedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q  <= 12'h000;
         done_o <= 1'b0;
      end else if (clear_i) begin
         cnt_q  <= 12'h000;
         done_o <= 1'b0;
      end else if (!done_o) begin
         cnt_q  <= cnt_q + 12'h001;
         done_o <= (cnt_q == limit); // 4096 or 32 cycles
      end
   end
endmodule

// ### rtl/elc_exception_ctrl.v
// exception arbitration and wait/stop sequencing for the cpu core
`timescale 1ns/1ps
`include "elc_defines.vh"
module elc_exception_ctrl (
   // clock and reset
   input  wire        core_clk_i,
   input  wire        reset_i,
   // cpu core handshake
   input  wire        instr_done_i,
   input  wire        swi_instr_i,
   input  wire        rti_instr_i,
   input  wire        wait_instr_i,
   input  wire        stop_instr_i,
   input  wire        mask_bit_i,
   input  wire        stack_done_i,
   // interrupt sources (pins, synchronised here)
   input  wire [7:0]  irq_req_i,
   input  wire [7:0]  irq_en_i,
   input  wire        break_req_i,
   input  wire        sys_reset_req_i,
   // option and control bits
   input  wire        stop_enable_option_i,
   input  wire        short_recovery_option_i,
   input  wire        watchdog_disable_option_i,
   input  wire        break_clear_flag_enable_i,
   input  wire        break_flag_wr_i,
   input  wire        break_flag_wdata_i,
   // module flag clearing
   input  wire        flag_clear_req_i,
   input  wire        flag_step1_i,
   input  wire        flag_step2_i,
   // cpu outputs
   output reg         irq_take_o,
   output reg  [3:0]  vector_sel_o,
   output reg         stack_pc_minus1_o,
   output reg         stack_index_high_o,
   output reg         set_mask_o,
   output reg         clear_mask_o,
   output reg         restore_regs_o,
   output reg         cpu_clk_en_o,
   output reg         periph_clk_en_o,
   output reg         osc_clk_en_o,
   output reg         watchdog_run_o,
   output reg         illegal_opcode_reset_o,
   output reg         in_break_o,
   output reg         break_stop_wait_flag_o,
   output reg         flag_clear_ok_o
);
   // one-hot sequencer states
   localparam [4:0] ST_RUN   = 5'b00001;
   localparam [4:0] ST_WAIT  = 5'b00010;
   localparam [4:0] ST_STOP  = 5'b00100;
   localparam [4:0] ST_RECOV = 5'b01000;
   localparam [4:0] ST_STACK = 5'b10000;

   // priority encoder: lowest index wins
   function [3:0] elc_pick;
      input [7:0] pend;
      integer i;
      begin
         elc_pick = `ELC_VEC_NONE;
         for (i = 7; i >= 0; i = i - 1)
            if (pend[i])
               elc_pick = `ELC_VEC_IRQ_BASE | i[3:0];
      end
   endfunction

   // wake vector: break outranks any pending module request
   function [3:0] elc_wake_vec;
      input       brk;
      input [3:0] hw_vec;
      begin
         elc_wake_vec = brk ? `ELC_VEC_SWI : hw_vec;
      end
   endfunction

   // wait or stop proper, before any recovery starts
   function elc_sleeping;
      input [4:0] st;
      begin
         elc_sleeping = (st == ST_WAIT) || (st == ST_STOP);
      end
   endfunction

   // two-flop synchronisers for pin-side requests; only stage two is read
   reg [7:0] irq_s1_q;
   reg [7:0] irq_s2_q;
   reg       brk_s1_q;
   reg       brk_s2_q;
   reg       rst_s1_q;
   reg       rst_s2_q;

   // module interrupt request lines
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_s1_q <= 8'h00;
         irq_s2_q <= 8'h00;
      end else begin
         irq_s1_q <= irq_req_i;
         irq_s2_q <= irq_s1_q;
      end
   end

   // break request from the break module
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         brk_s1_q <= 1'b0;
         brk_s2_q <= 1'b0;
      end else begin
         brk_s1_q <= break_req_i;
         brk_s2_q <= brk_s1_q;
      end
   end

   // any reset source; costs two cycles before the vector switches
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= sys_reset_req_i;
         rst_s2_q <= rst_s1_q;
      end
   end

   // sequencer state and latched arbitration
   reg [4:0] state_q;
   reg [3:0] latched_q;      // arbitration result held until serviced
   reg       latch_swi_q;
   reg       step1_q;        // first step of a two-step clear seen
   reg       recov_clear_q;
   wire      rec_done;

   // enabled requests and their arbitration result
   wire [7:0] pend_en  = irq_s2_q & irq_en_i;
   wire [3:0] pick     = elc_pick(pend_en);
   wire       hw_ok    = !mask_bit_i && (pick != `ELC_VEC_NONE);
   wire       wake_any = (pend_en != 8'h00) || brk_s2_q;

   // counter cleared in stop, released when recovery starts
   elc_recovery_counter u_rec (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .clear_i    (recov_clear_q),
      .short_i    (short_recovery_option_i),
      .done_o     (rec_done)
   );

   // main exception and low-power sequencer
   // reset first, then break > swi > stop > wait > module request
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q                <= ST_RUN;
         latched_q              <= `ELC_VEC_NONE;
         latch_swi_q            <= 1'b0;
         recov_clear_q          <= 1'b1;
         irq_take_o             <= 1'b0;
         vector_sel_o           <= `ELC_VEC_NONE;
         stack_pc_minus1_o      <= 1'b0;
         stack_index_high_o     <= 1'b0;
         set_mask_o             <= 1'b0;
         clear_mask_o           <= 1'b0;
         restore_regs_o         <= 1'b0;
         cpu_clk_en_o           <= 1'b1;
         periph_clk_en_o        <= 1'b1;
         osc_clk_en_o           <= 1'b1;
         illegal_opcode_reset_o <= 1'b0;
         in_break_o             <= 1'b0;
      end else begin
         irq_take_o             <= 1'b0;
         set_mask_o             <= 1'b0;
         clear_mask_o           <= 1'b0;
         restore_regs_o         <= rti_instr_i && instr_done_i;
         stack_index_high_o     <= 1'b0; // never pushed
         illegal_opcode_reset_o <= 1'b0;
         if (rst_s2_q) begin
            // reset bypasses arbitration entirely
            // clocks restored so the reset vector can be fetched
            state_q         <= ST_RUN;
            latched_q       <= `ELC_VEC_NONE;
            latch_swi_q     <= 1'b0;
            vector_sel_o    <= `ELC_VEC_RESET;
            cpu_clk_en_o    <= 1'b1;
            periph_clk_en_o <= 1'b1;
            osc_clk_en_o    <= 1'b1;
            recov_clear_q   <= 1'b0;
            in_break_o      <= 1'b0;
         end else begin
            case (state_q)
               // decisions only at an instruction boundary
               ST_RUN: begin
                  recov_clear_q <= 1'b0;
                  if (instr_done_i) begin // only at a boundary
                     if (brk_s2_q) begin
                        latched_q   <= `ELC_VEC_SWI;
                        latch_swi_q <= 1'b1;
                        in_break_o  <= 1'b1;
                        state_q     <= ST_STACK;
                     end else if (swi_instr_i) begin
                        latched_q   <= `ELC_VEC_SWI; // mask ignored
                        latch_swi_q <= 1'b1;
                        state_q     <= ST_STACK;
                     end else if (stop_instr_i && !stop_enable_option_i) begin
                        illegal_opcode_reset_o <= 1'b1;
                     end else if (stop_instr_i) begin
                        clear_mask_o    <= 1'b1;
                        cpu_clk_en_o    <= 1'b0;
                        periph_clk_en_o <= 1'b0; // cpu, peripheral and oscillator enables all gated
                        osc_clk_en_o    <= 1'b0;
                        recov_clear_q   <= 1'b1;
                        state_q         <= ST_STOP;
                     end else if (wait_instr_i) begin
                        clear_mask_o <= 1'b1;
                        cpu_clk_en_o <= 1'b0; // peripherals stay on
                        state_q      <= ST_WAIT;
                     end else if (hw_ok) begin
                        // a return with pending request re-enters here
                        latched_q   <= pick;
                        latch_swi_q <= 1'b0;
                        state_q     <= ST_STACK;
                     end
                  end
               end
               // peripherals still clocked, any wake source ends it
               ST_WAIT: begin
                  if (wake_any) begin
                     cpu_clk_en_o <= 1'b1;
                     latched_q    <= elc_wake_vec(brk_s2_q, pick);
                     latch_swi_q  <= brk_s2_q;
                     in_break_o   <= brk_s2_q;
                     state_q      <= ST_STACK; // stacking next cycle
                  end
               end
               // everything halted; wake restarts the oscillator only
               ST_STOP: begin
                  if (wake_any) begin
                     osc_clk_en_o  <= 1'b1;
                     recov_clear_q <= 1'b0; // recovery begins
                     latched_q     <= elc_wake_vec(brk_s2_q, pick);
                     latch_swi_q   <= brk_s2_q;
                     in_break_o    <= brk_s2_q;
                     state_q       <= ST_RECOV;
                  end
               end
               // oscillator settling, timed by the recovery counter
               ST_RECOV: begin
                  if (rec_done) begin // stacking after timeout
                     // cpu and peripheral clocks return together
                     cpu_clk_en_o    <= 1'b1;
                     periph_clk_en_o <= 1'b1;
                     state_q         <= ST_STACK;
                  end
               end
               // take and vector stand until stacking is reported done
               ST_STACK: begin
                  irq_take_o        <= !stack_done_i; // low in the cycle after done
                  vector_sel_o      <= latched_q; // held constant
                  stack_pc_minus1_o <= !latch_swi_q;
                  if (stack_done_i) begin
                     set_mask_o <= 1'b1;
                     latched_q  <= `ELC_VEC_NONE;
                     state_q    <= ST_RUN;
                  end
               end
               default: begin
                  state_q   <= ST_RUN;
                  latched_q <= `ELC_VEC_NONE;
               end
            endcase
            // leaving break on return from the break routine
            if (rti_instr_i && instr_done_i)
               in_break_o <= 1'b0;
         end
      end
   end

   // watchdog keeps running in wait unless disabled
   // a stopped oscillator halts it along with everything else
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i)
         watchdog_run_o <= 1'b0;
      else
         watchdog_run_o <= !watchdog_disable_option_i && (state_q != ST_STOP)
                           && (state_q != ST_RECOV);
   end

   // break stop/wait flag: set beats the zero write
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i)
         break_stop_wait_flag_o <= 1'b0;
      else if (brk_s2_q && elc_sleeping(state_q))
         break_stop_wait_flag_o <= 1'b1;
      else if (break_flag_wr_i && !break_flag_wdata_i)
         break_stop_wait_flag_o <= 1'b0;
   end

   // first step of a two-step clear; survives break so step two can finish later
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i)
         step1_q <= 1'b0;
      else if (flag_step1_i)
         step1_q <= 1'b1;
      else if (flag_clear_ok_o)
         step1_q <= 1'b0;
   end

   // flag-clear gating; in break only the clear enable lets a clear through
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i)
         flag_clear_ok_o <= 1'b0;
      else if (in_break_o)
         flag_clear_ok_o <= break_clear_flag_enable_i && flag_clear_req_i;
      else
         flag_clear_ok_o <= flag_clear_req_i || (step1_q && flag_step2_i);
   end
endmodule

// ### tb/elc_exception_checker_assertions.sv
// bound assertions for the exception and low-power controller
`timescale 1ns/1ps
module elc_exception_checker (
   // clock, reset and cpu side
   input wire       core_clk_i,
   input wire       reset_i,
   input wire       instr_done_i,
   input wire       swi_instr_i,
   input wire       stop_instr_i,
   input wire       stack_done_i,
   input wire       break_req_i,
   input wire       sys_reset_req_i,
   input wire       stop_enable_option_i,
   input wire       watchdog_disable_option_i,
   // outputs watched
   input wire       irq_take_o,
   input wire [3:0] vector_sel_o,
   input wire       stack_pc_minus1_o,
   input wire       stack_index_high_o,
   input wire       set_mask_o,
   input wire       cpu_clk_en_o,
   input wire       periph_clk_en_o,
   input wire       watchdog_run_o,
   input wire       illegal_opcode_reset_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   // boundary in run state with no competing exit in flight
   wire run_edge = instr_done_i && cpu_clk_en_o && !irq_take_o && !break_req_i && !sys_reset_req_i;
   a_swi_unmasked_vector: assert property (run_edge && swi_instr_i |-> ##2 irq_take_o &&
      vector_sel_o == 4'h1 && !stack_pc_minus1_o) else $error("swi take wrong");
   a_hw_pc_minus: assert property (irq_take_o && vector_sel_o[3] |-> stack_pc_minus1_o)
      else $error("hw take does not stack pc minus one");
   a_take_holds_vector: assert property (irq_take_o && !stack_done_i && !sys_reset_req_i
      |=> irq_take_o && $stable(vector_sel_o)) else $error("latched vector moved");
   a_mask_after_stack: assert property (irq_take_o && stack_done_i |=> set_mask_o && !irq_take_o)
      else $error("mask not set after stacking");
   a_index_high_kept: assert property (irq_take_o |-> !stack_index_high_o)
      else $error("index high stacked");
   a_stop_gates_clocks: assert property (run_edge && stop_instr_i && stop_enable_option_i
      && !swi_instr_i |-> ##[1:2] !cpu_clk_en_o && !periph_clk_en_o) else $error("stop kept clocks");
   a_stop_illegal_reset: assert property (run_edge && stop_instr_i && !stop_enable_option_i
      && !swi_instr_i |-> ##[1:2] illegal_opcode_reset_o) else $error("no illegal opcode reset");
   a_watchdog_runs: assert property ((!watchdog_disable_option_i && periph_clk_en_o)[*2]
      |-> watchdog_run_o) else $error("watchdog halted");
   // main scenarios reached
   c_swi_take: cover property (irq_take_o && vector_sel_o == 4'h1);
   c_illegal: cover property (illegal_opcode_reset_o);
   c_stopped: cover property (!cpu_clk_en_o && !periph_clk_en_o);
endmodule
bind elc_exception_ctrl elc_exception_checker elc_exception_checker_inst (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .instr_done_i(instr_done_i),
   .swi_instr_i(swi_instr_i), .stop_instr_i(stop_instr_i), .stack_done_i(stack_done_i),
   .break_req_i(break_req_i), .sys_reset_req_i(sys_reset_req_i),
   .stop_enable_option_i(stop_enable_option_i),
   .watchdog_disable_option_i(watchdog_disable_option_i), .irq_take_o(irq_take_o),
   .vector_sel_o(vector_sel_o), .stack_pc_minus1_o(stack_pc_minus1_o),
   .stack_index_high_o(stack_index_high_o), .set_mask_o(set_mask_o),
   .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
   .watchdog_run_o(watchdog_run_o), .illegal_opcode_reset_o(illegal_opcode_reset_o));

// ### tb/elc_cpu_model.sv
// cpu core stand-in answering each take with a stacking-done pulse
`timescale 1ns/1ps
module elc_cpu_model (
   // clock and reset
   input  wire       core_clk_i,
   input  wire       reset_i,
   // stacking handshake
   input  wire       take_i,
   input  wire [3:0] delay_i,
   output reg        done_o
);
   reg [3:0] cnt_q;
   // stacking lasts delay_i+1 cycles; one pulse only, so no second take is faked
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q  <= 4'h0;
         done_o <= 1'b0;
      end else begin
         done_o <= take_i && !done_o && cnt_q == delay_i;
         cnt_q  <= (take_i && !done_o) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule

// ### tb/elc_exception_ctrl_bench.sv
// self-checking bench for the exception and low-power controller
`timescale 1ns/1ps
module elc_exception_ctrl_bench;
   reg        clk, rst, idone, software_interrupt_instr, return_from_interrupt_instr, wt, stp, mask, brk, sreq, sten, shrt, wdd, break_clear_flag_enable, fwr, creq;
   reg        fwd, fs1, fs2;
   reg  [7:0] irq, en;
   reg  [4:0] seen;
   reg  [3:0] delay;
   integer    fails, tests_run, cycles, n;
   wire       take, pcm, idxh, setm, clrm, rstr, cpuen, peren, oscen, wdr, ilop, inbrk, bsw, ok, sdone;
   wire [3:0] vsel;
   elc_exception_ctrl elc_exception_ctrl_inst (.core_clk_i(clk), .reset_i(rst),
      .instr_done_i(idone), .swi_instr_i(software_interrupt_instr), .rti_instr_i(return_from_interrupt_instr), .wait_instr_i(wt),
      .stop_instr_i(stp), .mask_bit_i(mask), .stack_done_i(sdone), .irq_req_i(irq), .irq_en_i(en),
      .break_req_i(brk), .sys_reset_req_i(sreq), .stop_enable_option_i(sten),
      .short_recovery_option_i(shrt), .watchdog_disable_option_i(wdd),
      .break_clear_flag_enable_i(break_clear_flag_enable), .break_flag_wr_i(fwr), .break_flag_wdata_i(fwd),
      .flag_clear_req_i(creq), .flag_step1_i(fs1), .flag_step2_i(fs2), .irq_take_o(take),
      .vector_sel_o(vsel), .stack_pc_minus1_o(pcm), .stack_index_high_o(idxh), .set_mask_o(setm),
      .clear_mask_o(clrm), .restore_regs_o(rstr), .cpu_clk_en_o(cpuen), .periph_clk_en_o(peren),
      .osc_clk_en_o(oscen), .watchdog_run_o(wdr), .illegal_opcode_reset_o(ilop),
      .in_break_o(inbrk), .break_stop_wait_flag_o(bsw), .flag_clear_ok_o(ok));
   elc_cpu_model elc_cpu_model_inst (.core_clk_i(clk), .reset_i(rst), .take_i(take),
      .delay_i(delay), .done_o(sdone));
   // clock, and pulse catcher so one-cycle outputs are never missed
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      seen <= seen | {rstr, setm, clrm, ilop, ok};
      cycles = cycles + 1;
      if (cycles == 9000) begin
         fails = fails + 1;
         complete_run;
      end
   end
   task check(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
         end
      end
   endtask
   task step(input integer k);
      repeat (k) @(negedge clk);
   endtask
   // one instruction boundary carrying the opcode kind
   task instr(input [3:0] kind);
      begin
         {software_interrupt_instr, wt, stp, return_from_interrupt_instr} = kind;
         idone = 1'b1;
         step(1);
         {software_interrupt_instr, wt, stp, return_from_interrupt_instr, idone} = 5'h00;
      end
   endtask
   task wait_take;
      for (n = 0; take !== 1'b1 && n < 5000; n = n + 1) step(1);
   endtask
   task wait_idle;
      begin
         for (n = 0; take === 1'b1 && n < 50; n = n + 1) step(1);
         step(1); // the catcher samples closing pulses one edge later
      end
   endtask
   task t_swi;
      begin
         mask = 1'b1;
         seen = 5'h00;
         instr(4'h8);
         step(1);
         check({take, vsel, pcm, idxh}, {1'b1, 4'h1, 2'b00});
         wait_idle;
         check(seen[3], 1'b1);
      end
   endtask
   task t_hw;
      begin
         {mask, irq, en} = {1'b0, 8'h28, 8'hFF};
         step(4);
         instr(4'h0);
         step(1);
         check({take, vsel, pcm}, {1'b1, 4'hB, 1'b1});
         wait_idle;
         instr(4'h0);
         step(1);
         check({take, vsel}, {1'b1, 4'hB});
         wait_idle;
         mask = 1'b1;
         instr(4'h0);
         step(1);
         check(take, 1'b0);
         {mask, en} = {1'b0, 8'hF7};
         instr(4'h0);
         step(1);
         check({take, vsel}, {1'b1, 4'hD});
         wait_idle;
         irq = 8'h00;
         step(4);
      end
   endtask
   task t_stop(input en_opt, input sh);
      begin
         {sten, shrt, seen} = {en_opt, sh, 5'h00};
         instr(4'h2);
         step(2);
         if (!en_opt) check({seen[1], cpuen}, 2'b11);
         if (en_opt) begin
            check({cpuen, peren, oscen, seen[2]}, 4'h1);
            irq = 8'h01;
            wait_take;
            check(n >= (sh ? 32 : 4096) && n <= (sh ? 44 : 4108), 1'b1);
            check({vsel, cpuen, peren, oscen}, {4'h8, 3'b111});
            wait_idle;
            irq = 8'h00;
            step(4);
         end
      end
   endtask
   task t_wait_break;
      begin
         {mask, seen, break_clear_flag_enable, fwd} = {1'b1, 5'h00, 1'b0, 1'b0};
         instr(4'h4);
         fs1 = 1'b1; // first step of a two-step clear before break
         step(1);
         fs1 = 1'b0;
         step(1);
         check({seen[2], cpuen, peren, wdr}, 4'hB);
         {mask, brk} = 2'b01;
         wait_take;
         check({vsel, bsw, inbrk}, {4'h1, 2'b11});
         brk = 1'b0;
         wait_idle;
         {creq, fs2, seen} = {2'b11, 5'h00};
         step(1);
         {creq, fs2} = 2'b00;
         step(3);
         check({inbrk, seen[0]}, 2'b10);
         instr(4'h1);
         fs2 = 1'b1;
         step(1);
         fs2 = 1'b0;
         step(2);
         check({inbrk, seen[4], seen[0]}, 3'b011);
         brk = 1'b1;
         step(3);
         instr(4'h0);
         wait_take;
         brk = 1'b0;
         wait_idle;
         {break_clear_flag_enable, creq, seen} = {2'b11, 5'h00};
         step(1);
         creq = 1'b0;
         step(3);
         check({inbrk, seen[0]}, 2'b11);
         instr(4'h1);
         {fwr, fwd} = 2'b11;
         step(1);
         check(bsw, 1'b1);
         fwd = 1'b0;
         step(1);
         fwr = 1'b0;
         step(1);
         check({inbrk, bsw}, 2'b00);
      end
   endtask
   task complete_run;
      begin
         if (fails == 0 && tests_run > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      {rst, idone, software_interrupt_instr, return_from_interrupt_instr, wt, stp, mask, brk, sreq, sten, shrt, wdd, break_clear_flag_enable, fwr, creq} = 15'h4000;
      {irq, en, seen, delay, fails, tests_run, cycles} = 0;
      {fwd, fs1, fs2} = 3'b000;
      delay = 4'h3;
      step(3);
      rst = 1'b0;
      step(3);
      t_swi;
      t_hw;
      t_stop(1'b0, 1'b0);
      t_stop(1'b1, 1'b1);
      t_stop(1'b1, 1'b0);
      t_wait_break;
      sreq = 1'b1;
      step(4);
      check(vsel, 4'h2);
      complete_run;
   end
endmodule
